// [src/wait_seq_map.svh]
// constants of the static memory wait-state sequencer
`ifndef WAIT_SEQ_MAP_SVH
`define WAIT_SEQ_MAP_SVH

`define WS_TDF_W       4
`define WS_EWS_W       2
`define WS_EWS_OFF     2'h0
`define WS_EWS_FROZEN  2'h2
`define WS_EWS_READY   2'h3
`define WS_SYNC_RST    1'h1

`endif

// [src/wait_seq_pkg.sv]
// types shared by the static memory wait-state sequencer
package wait_seq_pkg;

  typedef enum logic [3:0]
  {
    ST_IDLE   = 4'h0,
    ST_CSW    = 4'h1,
    ST_RELOAD = 4'h2,
    ST_TURN   = 4'h3,
    ST_EARLY  = 4'h4,
    ST_FLOAT  = 4'h5,
    ST_SETUP  = 4'h6,
    ST_PULSE  = 4'h7,
    ST_READY  = 4'h8,
    ST_HOLD   = 4'h9
  } seq_state_t;

endpackage

// [src/pin_sync.sv]
// three-stage pin synchroniser, output follows once stages two and three agree
`include "wait_seq_map.svh"
module pin_sync
(
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);
  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = pin_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3)
    begin
      s_nxt.lvl = s_r.s3;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= {4{`WS_SYNC_RST}};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign level_o = s_r.lvl;
endmodule

// [src/float_tracker.sv]
// data-float recovery counter: remaining cycles, owning chip select, optimisation bit
`include "wait_seq_map.svh"
module float_tracker #(
  parameter int CSW = 3
)
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 start_i,
  input  wire logic [`WS_TDF_W-1:0] count_i,
  input  wire logic [CSW-1:0]       cs_i,
  input  wire logic                 opt_i,
  output logic [`WS_TDF_W-1:0]      rem_o,
  output logic [CSW-1:0]            cs_o,
  output logic                      opt_o
);
  typedef struct packed
  {
    logic [`WS_TDF_W-1:0] rem;
    logic [CSW-1:0]       cs;
    logic                 opt;
  } flt_t;

  flt_t f_r;
  flt_t f_nxt;

  always_comb
  begin
    f_nxt = f_r;
    if (start_i)
    begin
      f_nxt.rem = count_i;
      f_nxt.cs  = cs_i;
      f_nxt.opt = opt_i;
    end
    else if (f_r.rem != '0)
    begin
      f_nxt.rem = f_r.rem - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      f_r <= '0;
    end
    else
    begin
      f_r <= f_nxt;
    end
  end

  assign rem_o = f_r.rem;
  assign cs_o  = f_r.cs;
  assign opt_o = f_r.opt;
endmodule

// [src/static_mem_wait_sequencer.sv]
// wait-state and access sequencer for the external static memory controller
// Function
// - one idle cycle between transfers on different chip selects
// - during that idle cycle all selects and strobes sit high
// - early-read wait only write-then-read same chip select, never with idle cycle
// - early-read wait when write strobe hold zero and read strobe setup zero
// - chip-select-controlled write, zero cs hold, zero cs read setup: early-read wait
// - strobe-controlled write, zero hold, late feedback strobe: early-read wait
// - mode register write forces a reload wait cycle that loads new parameters
// - reload wait not on top of idle cycle; same device still gets it
// - entering or leaving slow clock mode also forces a reload wait
// - read followed by write always gets one turnaround cycle, added on top
// - float recovery before read to other device or any write
// - float count per chip select, 0 to 15 cycles
// - pending float recovery never stalls internal memory accesses
// - float starts at read strobe rise or chip select rise, per read control
// - with float optimisation the next setup counts toward the float period
// - without optimisation float waits end the read; hold cycles overlap only under read-strobe control
// - wait select two frozen, three ready, zero ignores the wait input
// - wait stretches access relative to the controlling strobe
// - wait input only sampled during controlling strobe pulse phase
// - frozen mode: sequence counter and select and strobe outputs stand still while wait asserted; float counter keeps running
// - ready mode: check wait in last pulse cycle, suspend, then hold
`include "wait_seq_map.svh"
module static_mem_wait_sequencer #(
  parameter int CHIP_SELECT_N = 6,
  parameter int CSW = 3,
  parameter int TW  = 9,
  parameter int BW  = 4
)
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  input  wire logic                 req_valid_i,
  input  wire logic                 req_internal_i,
  input  wire logic                 req_write_i,
  input  wire logic [CSW-1:0]       req_cs_i,
  input  wire logic [BW-1:0]        req_be_i,
  output logic                      req_ready_o,
  output logic                      done_o,
  input  wire logic                 mode_write_i,
  input  wire logic                 slow_clock_i,
  input  wire logic                 write_ctrl_select_i,
  input  wire logic                 read_ctrl_select_i,
  input  wire logic [TW-1:0]        read_setup_i,
  input  wire logic [TW-1:0]        read_pulse_i,
  input  wire logic [TW-1:0]        read_strobe_hold_i,
  input  wire logic [TW-1:0]        write_strobe_setup_i,
  input  wire logic [TW-1:0]        write_pulse_i,
  input  wire logic [TW-1:0]        write_strobe_hold_i,
  input  wire logic [TW-1:0]        cs_read_setup_i,
  input  wire logic [TW-1:0]        cs_write_hold_i,
  input  wire logic [`WS_TDF_W-1:0] float_cycle_count_i,
  input  wire logic                 float_optimize_i,
  input  wire logic [`WS_EWS_W-1:0] ext_wait_select_i,
  input  wire logic                 ext_wait_n_i,
  input  wire logic                 write_strobe_fb_n_i,
  output logic [CHIP_SELECT_N-1:0]            chip_select_n_o,
  output logic                      read_strobe_n_o,
  output logic                      write_strobe_n_o,
  output logic [BW-1:0]             byte_select_n_o,
  output logic [BW-1:0]             byte_write_strobe_n_o,
  output logic                      float_busy_o
);
  typedef struct packed
  {
    wait_seq_pkg::seq_state_t st;
    logic [TW-1:0]            cnt;
    logic [CSW-1:0]           cur_cs;
    logic                     cur_wr;
    logic [BW-1:0]            be;
    logic                     prv_ok;
    logic                     prv_wr;
    logic [CSW-1:0]           prv_cs;
    logic                     f_cs;
    logic                     f_rl;
    logic                     f_tn;
    logic                     f_er;
    logic                     pend;
    logic                     slow_q;
    logic                     w_wcs;
    logic                     w_rcs;
    logic [TW-1:0]            w_rs;
    logic [TW-1:0]            w_rp;
    logic [TW-1:0]            w_rh;
    logic [TW-1:0]            w_ws;
    logic [TW-1:0]            w_wp;
    logic [TW-1:0]            w_wh;
    logic [TW-1:0]            w_csrs;
    logic [TW-1:0]            w_cswh;
    logic [`WS_TDF_W-1:0]     w_fcc;
    logic                     w_fopt;
    logic [`WS_EWS_W-1:0]     w_ews;
    logic                     done;
    logic [CHIP_SELECT_N-1:0]           cs_n;
    logic                     rd_n;
    logic                     wr_n;
    logic [BW-1:0]            bs_n;
    logic [BW-1:0]            bw_n;
  } seq_t;

  seq_t                 s_r;
  seq_t                 s_nxt;
  logic [1:0]           rst_q_r;
  logic                 rst_n;
  logic                 wait_n_s;
  logic                 fb_n_s;
  logic                 f_start;
  logic [`WS_TDF_W-1:0] f_rem;
  logic [CSW-1:0]       f_cs;
  logic                 f_opt;

  // reset enters asynchronously, releases through two flops
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_q_r <= 2'h0;
    end
    else
    begin
      rst_q_r <= {rst_q_r[0], 1'b1};
    end
  end
  assign rst_n = rst_q_r[1];

  pin_sync u_wait_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .pin_i     (ext_wait_n_i),
    .level_o   (wait_n_s)
  );

  pin_sync u_fb_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .pin_i     (write_strobe_fb_n_i),
    .level_o   (fb_n_s)
  );

  float_tracker #(.CSW(CSW)) u_float (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .start_i   (f_start),
    .count_i   (s_nxt.w_fcc),
    .cs_i      (s_nxt.cur_cs),
    .opt_i     (s_nxt.w_fopt),
    .rem_o     (f_rem),
    .cs_o      (f_cs),
    .opt_o     (f_opt)
  );

  function automatic wait_seq_pkg::seq_state_t pick(input logic c, input logic r,
                                                   input logic t, input logic e);
    if (c)
      pick = wait_seq_pkg::ST_CSW;
    else if (r)
      pick = wait_seq_pkg::ST_RELOAD;
    else if (t)
      pick = wait_seq_pkg::ST_TURN;
    else if (e)
      pick = wait_seq_pkg::ST_EARLY;
    else
      pick = wait_seq_pkg::ST_FLOAT;
  endfunction

  logic          go_setup;
  logic          go_pulse;
  logic          go_hold;
  logic          go_end;
  logic          early;
  logic          blk;
  logic          acc;
  logic          stb;
  logic [TW-1:0] setup_v;

  always_comb
  begin
    s_nxt    = s_r;
    go_setup = 1'b0;
    go_pulse = 1'b0;
    go_hold  = 1'b0;
    go_end   = 1'b0;
    f_start  = 1'b0;
    s_nxt.done   = 1'b0;
    s_nxt.slow_q = slow_clock_i;
    early = (s_r.w_wh == '0 && s_r.w_rs == '0)
          || (!s_r.w_wcs && s_r.w_cswh == '0 && s_r.w_csrs == '0)
          || (s_r.w_wcs && s_r.w_wh == '0 && !fb_n_s);
    unique case (s_r.st)
      wait_seq_pkg::ST_IDLE:
        if (req_valid_i)
        begin
          if (req_internal_i)
          begin
            s_nxt.done = 1'b1;
          end
          else
          begin
            s_nxt.cur_wr = req_write_i;
            s_nxt.cur_cs = req_cs_i;
            s_nxt.be     = req_be_i;
            s_nxt.f_cs   = s_r.prv_ok && req_cs_i != s_r.prv_cs;
            s_nxt.f_rl   = (s_r.pend || !s_r.prv_ok) && !s_nxt.f_cs;
            s_nxt.f_tn   = s_r.prv_ok && !s_r.prv_wr && req_write_i;
            s_nxt.f_er   = s_r.prv_ok && s_r.prv_wr && !req_write_i && !s_nxt.f_cs
                           && !s_nxt.f_rl && early;
            s_nxt.st     = pick(s_nxt.f_cs, s_nxt.f_rl, s_nxt.f_tn, s_nxt.f_er);
          end
        end
      wait_seq_pkg::ST_CSW, wait_seq_pkg::ST_RELOAD:
      begin
        // working copy only moves here, an access in flight never sees a write
        s_nxt.w_wcs  = write_ctrl_select_i;
        s_nxt.w_rcs  = read_ctrl_select_i;
        s_nxt.w_rs   = read_setup_i;
        s_nxt.w_rp   = read_pulse_i;
        s_nxt.w_rh   = read_strobe_hold_i;
        s_nxt.w_ws   = write_strobe_setup_i;
        s_nxt.w_wp   = write_pulse_i;
        s_nxt.w_wh   = write_strobe_hold_i;
        s_nxt.w_csrs = cs_read_setup_i;
        s_nxt.w_cswh = cs_write_hold_i;
        s_nxt.w_fcc  = float_cycle_count_i;
        s_nxt.w_fopt = float_optimize_i;
        s_nxt.w_ews  = ext_wait_select_i;
        s_nxt.pend   = 1'b0;
        s_nxt.f_cs   = 1'b0;
        s_nxt.f_rl   = 1'b0;
        s_nxt.st     = pick(1'b0, 1'b0, s_r.f_tn, s_r.f_er);
      end
      wait_seq_pkg::ST_TURN:
      begin
        s_nxt.f_tn = 1'b0;
        s_nxt.st   = pick(1'b0, 1'b0, 1'b0, s_r.f_er);
      end
      wait_seq_pkg::ST_EARLY:
      begin
        s_nxt.f_er = 1'b0;
        s_nxt.st   = wait_seq_pkg::ST_FLOAT;
      end
      wait_seq_pkg::ST_FLOAT:
        s_nxt.st = wait_seq_pkg::ST_FLOAT;
      wait_seq_pkg::ST_SETUP:
        if (s_r.cnt == '0)
          go_pulse = 1'b1;
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      wait_seq_pkg::ST_PULSE:
        if (s_r.w_ews == `WS_EWS_FROZEN && !wait_n_s)
          s_nxt.cnt = s_r.cnt;
        else if (s_r.cnt != '0)
          s_nxt.cnt = s_r.cnt - 1'b1;
        else if (s_r.w_ews == `WS_EWS_READY && !wait_n_s)
          s_nxt.st = wait_seq_pkg::ST_READY;
        else
          go_hold = 1'b1;
      wait_seq_pkg::ST_READY:
        if (wait_n_s)
          go_hold = 1'b1;
      wait_seq_pkg::ST_HOLD:
        if (s_r.cnt == '0)
          go_end = 1'b1;
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
    endcase
    // set wins over the clear done in a wait cycle
    if (mode_write_i || slow_clock_i != s_r.slow_q)
      s_nxt.pend = 1'b1;
    setup_v = s_nxt.cur_wr ? s_nxt.w_ws : s_nxt.w_rs;
    // internal accesses bypass this check altogether
    blk = f_rem != '0 && (s_nxt.cur_wr || s_nxt.cur_cs != f_cs)
          && !(f_opt && setup_v >= {{(TW-`WS_TDF_W){1'b0}}, f_rem});
    if (s_nxt.st == wait_seq_pkg::ST_FLOAT && !blk)
      go_setup = 1'b1;
    if (go_setup)
    begin
      if (setup_v != '0)
      begin
        s_nxt.st  = wait_seq_pkg::ST_SETUP;
        s_nxt.cnt = setup_v - 1'b1;
      end
      else
        go_pulse = 1'b1;
    end
    if (go_pulse)
    begin
      s_nxt.st  = wait_seq_pkg::ST_PULSE;
      s_nxt.cnt = (s_nxt.cur_wr ? s_nxt.w_wp : s_nxt.w_rp) - 1'b1;
    end
    if (go_hold)
    begin
      if ((s_nxt.cur_wr ? s_nxt.w_wh : s_nxt.w_rh) != '0)
      begin
        s_nxt.st  = wait_seq_pkg::ST_HOLD;
        s_nxt.cnt = (s_nxt.cur_wr ? s_nxt.w_wh : s_nxt.w_rh) - 1'b1;
      end
      else
        go_end = 1'b1;
    end
    if (go_end)
    begin
      s_nxt.st     = wait_seq_pkg::ST_IDLE;
      s_nxt.done   = 1'b1;
      s_nxt.prv_ok = 1'b1;
      s_nxt.prv_wr = s_nxt.cur_wr;
      s_nxt.prv_cs = s_nxt.cur_cs;
    end
    // read-strobe control starts float at strobe rise, else at select rise
    f_start = !s_nxt.cur_wr && ((go_hold && s_nxt.w_rcs) || (go_end && !s_nxt.w_rcs));
    acc = s_nxt.st inside {wait_seq_pkg::ST_SETUP, wait_seq_pkg::ST_PULSE,
                           wait_seq_pkg::ST_READY, wait_seq_pkg::ST_HOLD};
    stb = s_nxt.st inside {wait_seq_pkg::ST_PULSE, wait_seq_pkg::ST_READY};
    // a frozen pulse keeps state and counter, so every select and strobe output repeats
    s_nxt.cs_n = '1;
    if (acc)
      s_nxt.cs_n[s_nxt.cur_cs] = 1'b0;
    s_nxt.rd_n = !(stb && !s_nxt.cur_wr);
    s_nxt.wr_n = !(stb && s_nxt.cur_wr);
    s_nxt.bs_n = acc ? ~s_nxt.be : '1;
    s_nxt.bw_n = (stb && s_nxt.cur_wr) ? ~s_nxt.be : '1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r      <= '0;
      s_r.st   <= wait_seq_pkg::ST_IDLE;
      s_r.cs_n <= '1;
      s_r.rd_n <= 1'b1;
      s_r.wr_n <= 1'b1;
      s_r.bs_n <= '1;
      s_r.bw_n <= '1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign req_ready_o           = s_r.st == wait_seq_pkg::ST_IDLE;
  assign done_o                = s_r.done;
  assign chip_select_n_o       = s_r.cs_n;
  assign read_strobe_n_o       = s_r.rd_n;
  assign write_strobe_n_o      = s_r.wr_n;
  assign byte_select_n_o       = s_r.bs_n;
  assign byte_write_strobe_n_o = s_r.bw_n;
  assign float_busy_o          = f_rem != '0;

  sequence s_ext_acc;
    s_r.st == wait_seq_pkg::ST_IDLE && req_valid_i && !req_internal_i;
  endsequence

  sequence s_frozen;
    s_r.st == wait_seq_pkg::ST_PULSE && s_r.w_ews == `WS_EWS_FROZEN && !wait_n_s;
  endsequence

  AST_CS_WAIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_ext_acc and (s_r.prv_ok && req_cs_i != s_r.prv_cs) |=> s_r.st == wait_seq_pkg::ST_CSW)
    else $error("no idle cycle on chip select change");
  AST_CS_WAIT_HIGH: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_r.st == wait_seq_pkg::ST_CSW |-> &chip_select_n_o && read_strobe_n_o
      && &byte_select_n_o && &byte_write_strobe_n_o)
    else $error("control line low during chip select wait");
  AST_EARLY_ALONE: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_r.st == wait_seq_pkg::ST_EARLY |-> $past(s_r.st) != wait_seq_pkg::ST_CSW
      && $past(s_r.st) != wait_seq_pkg::ST_RELOAD && !s_r.cur_wr)
    else $error("early read wait misplaced");
  AST_RELOAD: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (s_r.st == wait_seq_pkg::ST_IDLE && mode_write_i) ##1 (s_ext_acc
      and (req_cs_i == s_r.prv_cs)) |=> s_r.st == wait_seq_pkg::ST_RELOAD)
    else $error("reload wait missing after mode write");
  AST_TURN: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_ext_acc and (s_r.prv_ok && !s_r.prv_wr && req_write_i)
      |-> ##[1:3] s_r.st == wait_seq_pkg::ST_TURN)
    else $error("read to write turnaround missing");
  AST_INTERNAL: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_r.st == wait_seq_pkg::ST_IDLE && req_valid_i && req_internal_i |-> req_ready_o ##1 done_o)
    else $error("internal access stalled");
  AST_FROZEN: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_frozen |=> $stable(s_r.cnt) && $stable(chip_select_n_o) && $stable(read_strobe_n_o)
      && $stable(write_strobe_n_o))
    else $error("state moved while frozen");
  AST_READY: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_r.st == wait_seq_pkg::ST_READY && wait_n_s |=> s_r.st != wait_seq_pkg::ST_READY
      && read_strobe_n_o && write_strobe_n_o)
    else $error("ready mode did not resume");
  AST_WAIT_OFF: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_r.st == wait_seq_pkg::ST_PULSE && s_r.w_ews == `WS_EWS_OFF
      |=> s_r.st != wait_seq_pkg::ST_READY && $changed(s_r.cnt) || s_r.st != wait_seq_pkg::ST_PULSE)
    else $error("wait honoured while disabled");
  AST_FLOAT: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    // the block decision is made a cycle ahead, the counter may reach zero meanwhile
    s_r.st == wait_seq_pkg::ST_FLOAT |-> $past(float_busy_o))
    else $error("float wait without pending float");
endmodule

// [verif/ext_dev_model.sv]
// far-side static device model: wait answer to a strobe and write strobe echo
module ext_dev_model
(
  input  wire logic       clk_sys_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic       write_strobe_n_i,
  input  wire logic [7:0] wait_len_i,
  input  wire logic [1:0] fb_late_i,
  output logic            ext_wait_n_o,
  output logic            write_strobe_fb_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_q      = 1'b1;
  logic wr_q      = 1'b1;
  int   wait_left = 0;
  int   late_left = 0;
  // wait is only ever an answer to a strobe that has just fallen
  always @(posedge clk_sys_i)
  begin
    rd_q      <= read_strobe_n_i;
    wr_q      <= write_strobe_n_i;
    wait_left <= ((rd_q && !read_strobe_n_i) || (wr_q && !write_strobe_n_i)) ?
                 int'(wait_len_i) : (wait_left > 0 ? wait_left - 1 : 0);
    late_left <= !write_strobe_n_i ? int'(fb_late_i) : (late_left > 0 ? late_left - 1 : 0);
  end
  // a heavily loaded strobe line may return high late, seen here as a trailing echo
  assign write_strobe_fb_n_o = write_strobe_n_i & (late_left == 0);
  // a released wait line rests at its pull-up level
  assign ext_wait_n_o = (wait_left == 0);
endmodule

// [verif/tb_static_mem_wait_sequencer.sv]
// self-checking bench of the static memory wait-state sequencer
module tb_static_mem_wait_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys_i = 1'b0, nrst_i = 1'b0, mon_on = 1'b0;
  logic       req_valid_i = 1'b0, req_internal_i = 1'b0, req_write_i = 1'b0;
  logic [2:0] req_cs_i = 3'h0;
  logic [3:0] req_be_i = 4'hf;
  logic       mode_write_i = 1'b0, slow_clock_i = 1'b0, float_optimize_i;
  logic       write_ctrl_select_i, read_ctrl_select_i;
  logic [8:0] read_setup_i, read_pulse_i, read_strobe_hold_i, cs_read_setup_i;
  logic [8:0] write_strobe_setup_i, write_pulse_i, write_strobe_hold_i, cs_write_hold_i;
  logic [3:0] float_cycle_count_i;
  logic [1:0] ext_wait_select_i, fb_late = 2'h0;
  logic [7:0] wait_len = 8'h0;
  logic       ext_wait_n_i, write_strobe_fb_n_i, req_ready_o, done_o, float_busy_o;
  logic       read_strobe_n_o, write_strobe_n_o;
  logic [5:0] chip_select_n_o;
  logic [3:0] byte_select_n_o, byte_write_strobe_n_o;
  int         bad_count = 0, checked = 0, hi_cnt = 0, last_gap = 0, lat, act, rdl;

  static_mem_wait_sequencer u_dut
  (
    .clk_sys_i, .nrst_i, .req_valid_i, .req_internal_i, .req_write_i, .req_cs_i, .req_be_i,
    .req_ready_o, .done_o, .mode_write_i, .slow_clock_i, .write_ctrl_select_i,
    .read_ctrl_select_i, .read_setup_i, .read_pulse_i, .read_strobe_hold_i,
    .write_strobe_setup_i, .write_pulse_i, .write_strobe_hold_i, .cs_read_setup_i,
    .cs_write_hold_i, .float_cycle_count_i, .float_optimize_i, .ext_wait_select_i,
    .ext_wait_n_i, .write_strobe_fb_n_i, .chip_select_n_o, .read_strobe_n_o,
    .write_strobe_n_o, .byte_select_n_o, .byte_write_strobe_n_o, .float_busy_o
  );

  ext_dev_model u_dev
  (
    .clk_sys_i, .read_strobe_n_i(read_strobe_n_o), .write_strobe_n_i(write_strobe_n_o),
    .wait_len_i(wait_len), .fb_late_i(fb_late), .ext_wait_n_o(ext_wait_n_i),
    .write_strobe_fb_n_o(write_strobe_fb_n_i)
  );

  always #25 clk_sys_i = ~clk_sys_i;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // idle cycles between accesses: count them and see the read strobe and byte lines parked high
  always @(negedge clk_sys_i)
  begin
    if (mon_on && (chip_select_n_o === 6'h3f))
    begin
      hi_cnt++;
      check("idle lines", 32'h1ff, {23'h0, read_strobe_n_o, byte_select_n_o, byte_write_strobe_n_o});
    end
    else
    begin
      if (hi_cnt > 0)
        last_gap = hi_cnt;
      hi_cnt = 0;
    end
  end

  task automatic cfg_default();
    {write_ctrl_select_i, read_ctrl_select_i, float_optimize_i} = 3'h6;
    {read_setup_i, read_pulse_i, read_strobe_hold_i} = {9'h1, 9'h2, 9'h1};
    {write_strobe_setup_i, write_pulse_i, write_strobe_hold_i} = {9'h1, 9'h2, 9'h1};
    {cs_read_setup_i, cs_write_hold_i, float_cycle_count_i, ext_wait_select_i} = {9'h1, 9'h1, 6'h0};
  endtask

  function automatic int ex_len(input logic wr);
    if (wr)
      return int'(write_strobe_setup_i) + int'(write_pulse_i) + int'(write_strobe_hold_i);
    return int'(read_setup_i) + int'(read_pulse_i) + int'(read_strobe_hold_i);
  endfunction

  task automatic mode_pulse();
    mode_write_i = 1'b1;
    @(negedge clk_sys_i);
    mode_write_i = 1'b0;
  endtask

  // one access, entered and left at a falling edge; counts cycles from take to done
  task automatic acc(input logic wr, input logic [2:0] cs, input logic intl);
    int n;
    n = 0;
    {req_valid_i, req_write_i, req_cs_i, req_internal_i} = {1'b1, wr, cs, intl};
    while (req_ready_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    {lat, act, rdl} = {32'd1, 32'd0, 32'd0};
    while (done_o !== 1'b1 && lat < 2000)
    begin
      act += (chip_select_n_o !== 6'h3f);
      rdl += (read_strobe_n_o === 1'b0);
      @(negedge clk_sys_i);
      lat++;
    end
    if (n >= 2000 || lat >= 2000)
    begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic xacc(input logic wr, input logic [2:0] cs, input logic intl, input int w, input int a);
    acc(wr, cs, intl);
    check("latency", 1 + w + a, lat);
    check("select cycles", a, act);
  endtask

  task automatic t_reset();
    check("lines after reset", 32'h7ff, {chip_select_n_o, read_strobe_n_o, write_strobe_n_o,
          float_busy_o, done_o, req_ready_o} ^ 32'h6);
    $display("test reset done");
  endtask

  task automatic t_reload();
    xacc(1'b0, 3'h0, 1'b0, 1, 4);
    xacc(1'b0, 3'h0, 1'b0, 0, 4);
    mode_pulse();
    xacc(1'b0, 3'h0, 1'b0, 1, 4);
    mode_pulse();
    xacc(1'b0, 3'h1, 1'b0, 1, 4);
    read_pulse_i = 9'h3;
    xacc(1'b0, 3'h1, 1'b0, 0, 4);
    mode_pulse();
    xacc(1'b0, 3'h1, 1'b0, 1, 5);
    read_pulse_i = 9'h2;
    mode_pulse();
    xacc(1'b0, 3'h1, 1'b0, 1, 4);
    // a change seen at the taking edge is owed to the access after it
    slow_clock_i = 1'b1;
    @(negedge clk_sys_i);
    xacc(1'b0, 3'h1, 1'b0, 1, 4);
    slow_clock_i = 1'b0;
    @(negedge clk_sys_i);
    xacc(1'b0, 3'h1, 1'b0, 1, 4);
    $display("test reload done");
  endtask

  task automatic t_turn();
    xacc(1'b0, 3'h2, 1'b0, 1, 4);
    xacc(1'b1, 3'h3, 1'b0, 2, 4);
    xacc(1'b0, 3'h3, 1'b0, 0, 4);
    mode_pulse();
    xacc(1'b1, 3'h3, 1'b0, 2, 4);
    $display("test turnaround done");
  endtask

  task automatic t_early();
    {write_strobe_hold_i, read_setup_i} = 18'h0;
    mode_pulse();
    xacc(1'b1, 3'h3, 1'b0, 1, 3);
    xacc(1'b0, 3'h3, 1'b0, 1, 3);
    xacc(1'b1, 3'h4, 1'b0, 2, 3);
    xacc(1'b0, 3'h5, 1'b0, 1, 3);
    {write_ctrl_select_i, cs_write_hold_i, cs_read_setup_i} = 19'h0;
    {write_strobe_hold_i, read_setup_i} = {9'h1, 9'h1};
    mode_pulse();
    xacc(1'b1, 3'h5, 1'b0, 2, 4);
    xacc(1'b0, 3'h5, 1'b0, 1, 4);
    cfg_default();
    {write_strobe_hold_i, fb_late} = {9'h0, 2'h3};
    mode_pulse();
    xacc(1'b1, 3'h5, 1'b0, 2, 3);
    // synced echo trails the strobe by seven cycles: read once an on-time echo has cleared
    repeat (5) @(negedge clk_sys_i);
    xacc(1'b0, 3'h5, 1'b0, 1, 4);
    fb_late = 2'h0;
    $display("test early read done");
  endtask

  task automatic t_float();
    cfg_default();
    float_cycle_count_i = 4'hf;
    mode_pulse();
    xacc(1'b0, 3'h0, 1'b0, 1, 4);
    check("float busy", 1, float_busy_o);
    xacc(1'b0, 3'h0, 1'b1, 0, 0);
    xacc(1'b0, 3'h0, 1'b0, 0, 4);
    acc(1'b0, 3'h1, 1'b0);
    check("float gap strobe", 1, last_gap >= 14 && last_gap <= 17);
    {read_ctrl_select_i, float_cycle_count_i} = 5'h6;
    mode_pulse();
    acc(1'b0, 3'h1, 1'b0);
    acc(1'b0, 3'h2, 1'b0);
    check("float gap select", 1, last_gap >= 6 && last_gap <= 8);
    {read_ctrl_select_i, float_optimize_i, write_strobe_setup_i} = {2'h3, 9'hf};
    mode_pulse();
    xacc(1'b0, 3'h2, 1'b0, 1, 4);
    xacc(1'b1, 3'h2, 1'b0, 1, 18);
    {float_optimize_i, write_strobe_setup_i} = {1'b0, 9'h1};
    mode_pulse();
    xacc(1'b0, 3'h2, 1'b0, 1, 4);
    acc(1'b1, 3'h2, 1'b0);
    check("float gap write", 1, last_gap >= 5 && last_gap <= 8);
    $display("test float done");
  endtask

  task automatic t_wait();
    cfg_default();
    {read_pulse_i, write_pulse_i, ext_wait_select_i, wait_len} = {9'h6, 9'h6, 2'h2, 8'h3};
    mode_pulse();
    xacc(1'b0, 3'h2, 1'b0, 1, 11);
    acc(1'b1, 3'h2, 1'b0);
    check("frozen write", 11, act);
    for (int i = 0; i < 2; i++)
    begin
      ext_wait_select_i = 2'(i);
      mode_pulse();
      acc(1'b0, 3'h2, 1'b0);
      check("wait ignored", 8, act);
    end
    {ext_wait_select_i, wait_len} = {2'h3, 8'hc};
    mode_pulse();
    acc(1'b0, 3'h2, 1'b0);
    check("ready stretch", 1, rdl >= 13 && rdl <= 18);
    check("ready hold", rdl + 2, act);
    wait_len = 8'h0;
    $display("test external wait done");
  endtask

  initial
  begin
    cfg_default();
    repeat (12) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    mon_on = 1'b1;
    t_reset();
    t_reload();
    t_turn();
    t_early();
    t_float();
    t_wait();
    summarize();
  end
endmodule
